// File: src/ocr2_map.vh
/*
 * register map, field positions, reset values and encodings of the
 * second-level configuration and status bank.
 * assumes it is included by bare name and holds definitions only.
 */
`ifndef OCR2_MAP_VH
`define OCR2_MAP_VH

// byte addresses of the bank, 32 bits wide
`define OCR2_ADDR_W            32
`define OCR2_A_MODE            32'h00000000
`define OCR2_A_STROBE          32'h00000200
`define OCR2_A_WAIT            32'h00000300
`define OCR2_A_ERRPIN          32'h00000400
`define OCR2_A_CHECK           32'h00000500
`define OCR2_A_FAILSTAT        32'h00000800
`define OCR2_A_FADDR0          32'h00000c00
`define OCR2_A_FADDR1          32'h00000d00
`define OCR2_A_FADDR2          32'h00000e00
`define OCR2_A_FADDR3          32'h00000f00
`define OCR2_A_BOOT            32'h40000000
`define OCR2_A_CMDCHK          32'h80000000

// serial frame opcodes (values are arbitrary)
`define OCR2_OP_WRITE          8'h72
`define OCR2_OP_READ           8'h71

// serial frame shape: opcode, address, data
`define OCR2_CNT_W             6
`define OCR2_BITS_OP           6'h08
`define OCR2_BITS_HDR          6'h28
`define OCR2_BITS_FRAME        6'h30

// writable masks, reserved bits forced to their defaults
`define OCR2_MASK_MODE         8'h03
`define OCR2_MASK_STROBE       8'h03
`define OCR2_MASK_WAIT         8'h07
`define OCR2_MASK_ERRPIN       8'h03
`define OCR2_MASK_CHECK        8'h71
`define OCR2_MASK_BOOT         8'h0b

// reset values
`define OCR2_RST_VOL           8'h00
`define OCR2_RST_BOOT          8'hff
`define OCR2_CLEAR_VALUE       8'h00

// interface mode codes
`define OCR2_MODE_SPI          2'b00
`define OCR2_MODE_SINGLE       2'b01
`define OCR2_MODE_DOUBLE       2'b10
`define OCR2_MODE_INHIBIT      2'b11

// field positions
`define OCR2_CHK_SIZE_HI       6
`define OCR2_CHK_SIZE_LO       5
`define OCR2_CHK_PIN_BIT       4
`define OCR2_PRE_SEL_BIT       0
`define OCR2_FS_VALID_BIT      7
`define OCR2_PARITY_DIS_BIT    3
`define OCR2_CMDCHK_BIT        4

// error pin conditions
`define OCR2_ERR_TWO_DBL       2'b00
`define OCR2_ERR_ANY_DBL       2'b01
`define OCR2_ERR_TWO           2'b10
`define OCR2_ERR_ANY           2'b11

// chunk sizes in bytes
`define OCR2_CHUNK_16          8'h10
`define OCR2_CHUNK_32          8'h20
`define OCR2_CHUNK_64          8'h40
`define OCR2_CHUNK_128         8'h80

// wait cycles: 20 at code 0, two fewer per step
`define OCR2_WAIT_MAX          5'h14

// counter saturation
`define OCR2_CNT_MAX           4'hf
`define OCR2_CNT_ONE           4'h1

// preamble patterns
`define OCR2_PRE0_LINES        16'h349a
`define OCR2_PRE0_LINE3        16'h3514
`define OCR2_PRE1_ALL          16'h5555

`endif

// File: src/ocr2_sync.v
/*
 * two flip-flop synchroniser for one level from outside the clock domain.
 * assumes the level is slow against clk; only q may be read.
 */
`timescale 1ns/100ps
`default_nettype none

module ocr2_sync (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// level in and out
	input  wire d,
	input  wire rst_val,
	output reg  q
);

	reg meta_reg;

	// first stage feeds only the second
	always @(posedge clk) begin
		if (!rst_n) begin
			// reset to the pin's idle level to avoid a false edge
			meta_reg <= rst_val;
			q        <= rst_val;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule // ocr2_sync

`default_nettype wire

// File: src/ocr2_top.v
/*
 * second-level configuration and status bank of the octal flash, with its
 * serial register port: opcode byte, 32-bit address, one data byte, msb first.
 * assumes the serial clock is slow enough for clk to find both its edges,
 * and that ecc and command check events come from logic on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ocr2_map.vh"

module ocr2_top (
	// clock and resets
	input  wire        clk,
	input  wire        rst_n,
	input  wire        por_n,
	// serial register port
	input  wire        sclk,
	input  wire        cs_n,
	input  wire        si,
	output reg         so,
	output reg         so_oe,
	// ecc events from the read path
	input  wire        ecc_event,
	input  wire        ecc_one_bit,
	input  wire        ecc_two_bit,
	input  wire        ecc_double_prog,
	input  wire [25:4] ecc_chunk_addr,
	// command check events
	input  wire        cmd_check_event,
	input  wire        preamble_output_enable,
	// configuration outputs
	output reg  [1:0]  octal_io_mode,
	output reg         strobe_in_single_rate,
	output reg         strobe_precycle,
	output reg  [2:0]  wait_cycle_code,
	output reg  [4:0]  wait_cycles,
	output reg  [7:0]  check_chunk_size,
	output reg         check_pin_output_enable,
	output reg         parity_check_active,
	output reg         error_flag_pin_n,
	output reg  [15:0] preamble_lines,
	output reg  [15:0] preamble_line3,
	output reg         preamble_drive
);

	// synchronised pins
	wire sclk_s;
	wire cs_n_s;
	wire si_s;
	reg  sclk_d_reg;

	ocr2_sync u_sync_sclk (
		.clk     (clk),
		.rst_n   (rst_n),
		.d       (sclk),
		.rst_val (1'b0),
		.q       (sclk_s)
	);
	ocr2_sync u_sync_cs (
		.clk     (clk),
		.rst_n   (rst_n),
		.d       (cs_n),
		.rst_val (1'b1),
		.q       (cs_n_s)
	);
	ocr2_sync u_sync_si (
		.clk     (clk),
		.rst_n   (rst_n),
		.d       (si),
		.rst_val (1'b0),
		.q       (si_s)
	);

	wire sclk_rise = sclk_s & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s & sclk_d_reg;
	// select sync idles high in reset, so release opens no false frame
	wire in_frame  = ~cs_n_s;

	// register storage
	reg [7:0]  mode_reg;
	reg [7:0]  strobe_reg;
	reg [7:0]  wait_reg;
	reg [7:0]  errpin_reg;
	reg [7:0]  check_reg;
	reg [7:0]  boot_reg;
	reg        fa_valid_reg;
	reg [2:0]  fail_flags_reg;
	reg [3:0]  fail_cnt_reg;
	reg [25:4] fail_addr_reg;
	reg        cmd_fail_reg;

	// serial engine state
	reg [`OCR2_CNT_W-1:0]  bit_cnt_reg;
	reg [7:0]              op_reg;
	reg [`OCR2_ADDR_W-1:0] addr_reg;
	reg [7:0]              data_reg;
	reg [7:0]              tx_reg;
	reg                    wr_strobe_reg;

	// read mux, unmapped addresses read zero
	reg [7:0] rd_data;
	always @* begin
		rd_data = 8'h00;
		case (addr_reg)
			`OCR2_A_MODE:     rd_data = mode_reg;
			`OCR2_A_STROBE:   rd_data = strobe_reg;
			`OCR2_A_WAIT:     rd_data = wait_reg;
			`OCR2_A_ERRPIN:   rd_data = errpin_reg;
			`OCR2_A_CHECK:    rd_data = check_reg;
			`OCR2_A_FAILSTAT: rd_data = {fa_valid_reg, fail_flags_reg, fail_cnt_reg};
			`OCR2_A_FADDR0:   rd_data = {fail_addr_reg[7:4], 4'h0};
			`OCR2_A_FADDR1:   rd_data = fail_addr_reg[15:8];
			`OCR2_A_FADDR2:   rd_data = fail_addr_reg[23:16];
			`OCR2_A_FADDR3:   rd_data = {6'h00, fail_addr_reg[25:24]};
			`OCR2_A_BOOT:     rd_data = boot_reg;
			`OCR2_A_CMDCHK:   rd_data = {3'h0, cmd_fail_reg, 4'h0};
			default:          rd_data = 8'h00;
		endcase
	end

	// serial shift: sample on rising, drive on falling edges of sclk
	always @(posedge clk) begin
		if (!rst_n) begin
			sclk_d_reg    <= 1'b0;
			bit_cnt_reg   <= {`OCR2_CNT_W{1'b0}};
			op_reg        <= 8'h00;
			addr_reg      <= {`OCR2_ADDR_W{1'b0}};
			data_reg      <= 8'h00;
			tx_reg        <= 8'h00;
			wr_strobe_reg <= 1'b0;
			so            <= 1'b0;
			so_oe         <= 1'b0;
		end else begin
			sclk_d_reg    <= sclk_s;
			wr_strobe_reg <= 1'b0;
			if (!in_frame) begin
				bit_cnt_reg <= {`OCR2_CNT_W{1'b0}};
				so_oe       <= 1'b0;
			end else if (sclk_rise && bit_cnt_reg != `OCR2_BITS_FRAME) begin
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				if (bit_cnt_reg < `OCR2_BITS_OP)
					op_reg <= {op_reg[6:0], si_s};
				else if (bit_cnt_reg < `OCR2_BITS_HDR)
					addr_reg <= {addr_reg[`OCR2_ADDR_W-2:0], si_s};
				else
					data_reg <= {data_reg[6:0], si_s};
				// last data bit of a write frame commits
				if (bit_cnt_reg == `OCR2_BITS_FRAME - 1'b1 && op_reg == `OCR2_OP_WRITE)
					wr_strobe_reg <= 1'b1;
				// header done on a read: clear the answer byte; the next falling edge loads it
				if (bit_cnt_reg == `OCR2_BITS_HDR - 1'b1 && op_reg == `OCR2_OP_READ)
					tx_reg <= 8'h00;
			end else if (sclk_fall && op_reg == `OCR2_OP_READ) begin
				// first falling edge after the header puts out the msb
				if (bit_cnt_reg == `OCR2_BITS_HDR) begin
					so     <= rd_data[7];
					tx_reg <= {rd_data[6:0], 1'b0};
					so_oe  <= 1'b1;
				end else if (bit_cnt_reg > `OCR2_BITS_HDR &&
				             bit_cnt_reg < `OCR2_BITS_FRAME) begin
					so     <= tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
				end else if (bit_cnt_reg == `OCR2_BITS_FRAME) begin
					so_oe  <= 1'b0;
				end
			end
		end
	end

	wire wr_hit_stat = wr_strobe_reg && addr_reg == `OCR2_A_FAILSTAT &&
	                   data_reg == `OCR2_CLEAR_VALUE;
	wire wr_hit_cmd  = wr_strobe_reg && addr_reg == `OCR2_A_CMDCHK &&
	                   data_reg == `OCR2_CLEAR_VALUE;

	// one-time bits: only a power-on brings them back to blank
	always @(posedge clk) begin
		if (!por_n) begin
			boot_reg <= `OCR2_RST_BOOT;
		end else if (wr_strobe_reg && addr_reg == `OCR2_A_BOOT) begin
			// programming only moves writable bits from one to zero
			boot_reg <= boot_reg & (data_reg | ~`OCR2_MASK_BOOT);
		end
	end

	// volatile configuration; mode follows the boot field at reset
	always @(posedge clk) begin
		if (!rst_n || !por_n) begin
			mode_reg   <= {6'h00, ~boot_reg[1:0]};
			strobe_reg <= `OCR2_RST_VOL;
			wait_reg   <= `OCR2_RST_VOL;
			errpin_reg <= `OCR2_RST_VOL;
			check_reg  <= `OCR2_RST_VOL;
		end else if (wr_strobe_reg) begin
			// reserved bits stay at zero whatever the host sends
			case (addr_reg)
				`OCR2_A_MODE:   mode_reg   <= data_reg & `OCR2_MASK_MODE;
				`OCR2_A_STROBE: strobe_reg <= data_reg & `OCR2_MASK_STROBE;
				`OCR2_A_WAIT:   wait_reg   <= data_reg & `OCR2_MASK_WAIT;
				`OCR2_A_ERRPIN: errpin_reg <= data_reg & `OCR2_MASK_ERRPIN;
				`OCR2_A_CHECK:  check_reg  <= data_reg & `OCR2_MASK_CHECK;
				default:        ;
			endcase
		end
	end

	// ecc status: clear first, a same-cycle event then wins
	always @(posedge clk) begin
		if (!rst_n || !por_n) begin
			fa_valid_reg   <= 1'b0;
			fail_flags_reg <= 3'h0;
			fail_cnt_reg   <= 4'h0;
			fail_addr_reg  <= 22'h000000;
		end else if (ecc_event) begin
			fail_flags_reg <= (wr_hit_stat ? 3'h0 : fail_flags_reg) |
			                  {ecc_double_prog, ecc_two_bit, ecc_one_bit};
			if (wr_hit_stat)
				fail_cnt_reg <= `OCR2_CNT_ONE;
			else if (fail_cnt_reg != `OCR2_CNT_MAX)
				fail_cnt_reg <= fail_cnt_reg + 1'b1;
			// address kept from the first failure only
			if (!fa_valid_reg || wr_hit_stat)
				fail_addr_reg <= ecc_chunk_addr;
			fa_valid_reg <= 1'b1;
		end else if (wr_hit_stat) begin
			fa_valid_reg   <= 1'b0;
			fail_flags_reg <= 3'h0;
			fail_cnt_reg   <= 4'h0;
		end
	end

	// command check status, gated by the active-low enable
	wire parity_on = ~boot_reg[`OCR2_PARITY_DIS_BIT];
	always @(posedge clk) begin
		if (!rst_n || !por_n)
			cmd_fail_reg <= 1'b0;
		else if (cmd_check_event && parity_on)
			cmd_fail_reg <= 1'b1;
		else if (wr_hit_cmd)
			cmd_fail_reg <= 1'b0;
	end

	// error pin condition from live status flags
	reg err_cond;
	always @* begin
		err_cond = 1'b0;
		case (errpin_reg[1:0])
			`OCR2_ERR_TWO_DBL: err_cond = fail_flags_reg[1] | fail_flags_reg[2];
			`OCR2_ERR_ANY_DBL: err_cond = |fail_flags_reg;
			`OCR2_ERR_TWO:     err_cond = fail_flags_reg[1];
			`OCR2_ERR_ANY:     err_cond = fail_flags_reg[0] | fail_flags_reg[1];
			default:           err_cond = 1'b0;
		endcase
	end

	// chunk size decode
	reg [7:0] chunk_bytes;
	always @* begin
		chunk_bytes = `OCR2_CHUNK_16;
		case (check_reg[`OCR2_CHK_SIZE_HI:`OCR2_CHK_SIZE_LO])
			2'b00:   chunk_bytes = `OCR2_CHUNK_16;
			2'b01:   chunk_bytes = `OCR2_CHUNK_32;
			2'b10:   chunk_bytes = `OCR2_CHUNK_64;
			2'b11:   chunk_bytes = `OCR2_CHUNK_128;
			default: chunk_bytes = `OCR2_CHUNK_16;
		endcase
	end

	// registered outputs; one cycle behind the stored fields
	always @(posedge clk) begin
		if (!rst_n || !por_n) begin
			// same value as the stored field, so no step at release
			octal_io_mode           <= ~boot_reg[1:0];
			strobe_in_single_rate   <= 1'b0;
			strobe_precycle         <= 1'b0;
			wait_cycle_code         <= 3'h0;
			wait_cycles             <= `OCR2_WAIT_MAX;
			check_chunk_size        <= `OCR2_CHUNK_16;
			check_pin_output_enable <= 1'b0;
			parity_check_active     <= 1'b0;
			error_flag_pin_n        <= 1'b1;
			preamble_lines          <= `OCR2_PRE0_LINES;
			preamble_line3          <= `OCR2_PRE0_LINE3;
			preamble_drive          <= 1'b0;
		end else begin
			octal_io_mode           <= mode_reg[1:0];
			strobe_in_single_rate   <= strobe_reg[1];
			strobe_precycle         <= strobe_reg[0];
			wait_cycle_code         <= wait_reg[2:0];
			wait_cycles             <= `OCR2_WAIT_MAX - {1'b0, wait_reg[2:0], 1'b0};
			check_chunk_size        <= chunk_bytes;
			check_pin_output_enable <= check_reg[`OCR2_CHK_PIN_BIT];
			parity_check_active     <= parity_on;
			error_flag_pin_n        <= ~err_cond;
			// patterns are fixed; only the select moves them
			if (check_reg[`OCR2_PRE_SEL_BIT]) begin
				preamble_lines <= `OCR2_PRE1_ALL;
				preamble_line3 <= `OCR2_PRE1_ALL;
			end else begin
				preamble_lines <= `OCR2_PRE0_LINES;
				preamble_line3 <= `OCR2_PRE0_LINE3;
			end
			preamble_drive          <= preamble_output_enable;
		end
	end

endmodule // ocr2_top

`default_nettype wire

// File: tb/ocr2_chk_sva.sv
/*
 * concurrent checks on the ports of the configuration bank.
 * assumes it is bound to ocr2_top; both resets quiet every check.
 */
`timescale 1ns/100ps
`default_nettype none

module ocr2_chk (
	// clock and resets
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        por_n,
	// serial port
	input wire logic        cs_n,
	input wire logic        so_oe,
	// events
	input wire logic        ecc_event,
	input wire logic        ecc_two_bit,
	input wire logic        preamble_output_enable,
	// configuration outputs
	input wire logic [1:0]  octal_io_mode,
	input wire logic [2:0]  wait_cycle_code,
	input wire logic [4:0]  wait_cycles,
	input wire logic [7:0]  check_chunk_size,
	input wire logic        error_flag_pin_n,
	input wire logic [15:0] preamble_lines,
	input wire logic [15:0] preamble_line3,
	input wire logic        preamble_drive
);
	// one domain; a reset of either kind halts checking
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !por_n);

	property p_wait;
		wait_cycles == 5'h14 - {wait_cycle_code, 1'b0};
	endproperty
	a_wait: assert property (p_wait) else $error("wait count off its code");

	property p_chunk;
		check_chunk_size inside {8'h10, 8'h20, 8'h40, 8'h80};
	endproperty
	a_chunk: assert property (p_chunk) else $error("chunk size not legal");

	property p_pre;
		(preamble_lines == 16'h349a && preamble_line3 == 16'h3514)
			|| (preamble_lines == 16'h5555 && preamble_line3 == 16'h5555);
	endproperty
	a_pre: assert property (p_pre) else $error("preamble pair wrong");

	property p_drive;
		preamble_drive == $past(preamble_output_enable);
	endproperty
	a_drive: assert property (p_drive) else $error("preamble drive not following");

	// a two-bit failure lowers the pin under every condition code
	property p_err;
		ecc_event && ecc_two_bit |-> ##2 !error_flag_pin_n;
	endproperty
	a_err: assert property (p_err) else $error("error pin missed two-bit event");

	property p_oe_cause;
		$rose(so_oe) |-> !$past(cs_n, 8);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("read data outside a frame");

	property p_oe_hold;
		$rose(so_oe) |-> so_oe [*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("read data cut short");

	// mode moves only on a committed frame or a reset
	property p_mode;
		$changed(octal_io_mode) |-> !$past(cs_n, 2) || !$past(rst_n) || !$past(por_n);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed without cause");

	c_ecc: cover property (ecc_event && ecc_two_bit);
	c_read: cover property ($rose(so_oe));
	c_pin: cover property ($fell(error_flag_pin_n));
endmodule // ocr2_chk

bind ocr2_top ocr2_chk u_chk (.clk(clk), .rst_n(rst_n), .por_n(por_n), .cs_n(cs_n),
	.so_oe(so_oe), .ecc_event(ecc_event), .ecc_two_bit(ecc_two_bit),
	.preamble_output_enable(preamble_output_enable), .octal_io_mode(octal_io_mode),
	.wait_cycle_code(wait_cycle_code), .wait_cycles(wait_cycles),
	.check_chunk_size(check_chunk_size), .error_flag_pin_n(error_flag_pin_n),
	.preamble_lines(preamble_lines), .preamble_line3(preamble_line3),
	.preamble_drive(preamble_drive));

`default_nettype wire

// File: tb/ocr2_host.sv
/*
 * host controller model for the serial register port.
 * assumes read data is taken on rising sclk, msb first.
 */
`timescale 1ns/100ps
`default_nettype none

module ocr2_host (
	// serial port
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	// idle: clock still, select high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// one frame; 80 ns period gives clk eight cycles per sclk half
	task automatic xfer(input logic [7:0] op, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [47:0] f;
		f = {op, a, d};
		q = 8'h00;
		#1 cs_n = 1'b0;
		#100;
		for (int i = 47; i >= 0; i--) begin
			si = f[i];
			#40 sclk = 1'b1;
			if (i < 8)
				q[i] = so;
			#40 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		// released line flips so a stale bit cannot pass
		si = ~si;
		#100;
	endtask
endmodule // ocr2_host

`default_nettype wire

// File: tb/ocr2_top_tb.sv
/*
 * self-checking bench for the configuration bank with a reference model.
 * assumes the host model and checker are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module ocr2_top_tb;
	wire  sclk, cs_n, si;
	logic clk, rst_n, por_n, so, so_oe, ev, e1, e2, ed, cmd_ev, pe;
	logic s_single, s_pre, par, pin_n, drive, chk_pin;
	logic [25:4] ea;
	logic [1:0]  mode;
	logic [2:0]  code;
	logic [4:0]  wcyc;
	logic [7:0]  chunk, boot, rq;
	logic [15:0] pl, pl3;
	int          err_count, check_count, cyc;
	// reference model state
	logic [7:0]  m_cfg [5];
	logic [2:0]  fs;
	logic [3:0]  cnt;
	logic        valid, cmdf;
	logic [25:4] fa;
	logic [31:0] la [13] = '{32'h0, 32'h200, 32'h300, 32'h400, 32'h500, 32'h800,
		32'hc00, 32'hd00, 32'he00, 32'hf00, 32'h40000000, 32'h80000000, 32'h100};

	ocr2_top u_dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .sclk(sclk), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .ecc_event(ev), .ecc_one_bit(e1),
		.ecc_two_bit(e2), .ecc_double_prog(ed), .ecc_chunk_addr(ea),
		.cmd_check_event(cmd_ev), .preamble_output_enable(pe), .octal_io_mode(mode),
		.strobe_in_single_rate(s_single), .strobe_precycle(s_pre),
		.wait_cycle_code(code), .wait_cycles(wcyc), .check_chunk_size(chunk),
		.check_pin_output_enable(chk_pin), .parity_check_active(par),
		.error_flag_pin_n(pin_n), .preamble_lines(pl), .preamble_line3(pl3),
		.preamble_drive(drive));
	// undriven data line shows the inverse so a stale bit cannot pass
	ocr2_host u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));

	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard, well above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			close_out();
		end
	end

	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// expected read data of every place in the bank
	function automatic logic [7:0] mread(logic [31:0] a);
		for (int i = 0; i < 5; i++)
			if (a == la[i])
				return m_cfg[i];
		case (a)
			32'h800: return {valid, fs, cnt};
			32'hc00: return {fa[7:4], 4'h0};
			32'hd00: return fa[15:8];
			32'he00: return fa[23:16];
			32'hf00: return {6'h00, fa[25:24]};
			32'h40000000: return boot;
			32'h80000000: return {3'h0, cmdf, 4'h0};
			default: return 8'h00;
		endcase
	endfunction

	// pin level from sticky flags: bit0 one, bit1 two, bit2 double
	function automatic logic pin_exp();
		case (m_cfg[3][1:0])
			2'b00: return !(fs[1] | fs[2]);
			2'b01: return fs == 3'b000;
			2'b10: return !fs[1];
			default: return !(fs[0] | fs[1]);
		endcase
	endfunction

	task automatic rd(logic [31:0] a);
		u_host.xfer(8'h71, a, 8'h00, rq);
		chk($sformatf("addr %h", a), {8'h00, mread(a)}, {8'h00, rq});
	endtask

	// write, then apply what the device is expected to keep
	task automatic wr(logic [31:0] a, logic [7:0] d);
		u_host.xfer(8'h72, a, d, rq);
		for (int i = 0; i < 5; i++)
			if (a == la[i])
				m_cfg[i] = d;
		if (a == 32'h800 && d == 8'h00)
			{valid, fs, cnt} = 8'h00;
		if (a == 32'h80000000 && d == 8'h00)
			cmdf = 1'b0;
		if (a == 32'h40000000)
			boot = boot & (d | 8'hf4);
		repeat (4) @(posedge clk);
	endtask

	task automatic ecc(logic [2:0] f);
		logic [25:4] a;
		a = 22'($urandom);
		@(posedge clk);
		ev <= 1'b1;
		{ed, e2, e1} <= f;
		ea <= a;
		@(posedge clk);
		ev <= 1'b0;
		if (!valid)
			fa = a;
		valid = 1'b1;
		fs = fs | f;
		if (cnt != 4'hf)
			cnt = cnt + 4'h1;
		repeat (3) @(posedge clk);
		#1 chk("error pin", pin_exp(), pin_n);
	endtask

	task automatic cmd();
		@(posedge clk);
		cmd_ev <= 1'b1;
		@(posedge clk);
		cmd_ev <= 1'b0;
		cmdf = cmdf | !boot[3];
		repeat (3) @(posedge clk);
	endtask

	task automatic cfg_out();
		chk("mode", m_cfg[0][1:0], mode);
		chk("strobe", m_cfg[1][1:0], {s_single, s_pre});
		chk("wait code", m_cfg[2][2:0], code);
		chk("wait", 5'h14 - {m_cfg[2][2:0], 1'b0}, wcyc);
		chk("chunk", 8'h10 << m_cfg[4][6:5], chunk);
		chk("check pin", m_cfg[4][4], chk_pin);
		chk("pre", m_cfg[4][0] ? 16'h5555 : 16'h349a, pl);
		chk("pre3", m_cfg[4][0] ? 16'h5555 : 16'h3514, pl3);
		chk("parity", !boot[3], par);
	endtask

	// rst_n alone keeps the boot byte; power-on blanks it
	task automatic do_reset(logic por);
		@(posedge clk);
		rst_n <= 1'b0;
		por_n <= !por;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		if (por)
			boot = 8'hff;
		foreach (m_cfg[i])
			m_cfg[i] = 8'h00;
		m_cfg[0] = {6'h00, ~boot[1:0]};
		{valid, fs, cnt, cmdf} = 9'h000;
		fa = '0;
		repeat (6) @(posedge clk);
	endtask

	initial begin
		{rst_n, por_n, ev, e1, e2, ed, cmd_ev, pe} = 8'h00;
		ea = '0;
		boot = 8'hff;
		void'($urandom(16));
		do_reset(1'b1);
		// reset values, read-only bytes and an unmapped place
		for (int i = 0; i < 13; i++)
			rd(la[i]);
		cfg_out();
		// every wait code and chunk size; reserved bits kept at default
		for (int k = 0; k < 8; k++) begin
			wr(la[2], 8'(k));
			wr(la[4], {1'b0, 2'(k), 5'($urandom) & 5'h11});
			wr(la[k % 2], 8'($urandom % 3));
			rd(la[k % 5]);
			cfg_out();
		end
		// each pin condition against one-bit, double and two-bit events
		for (int c = 0; c < 4; c++) begin
			wr(la[3], 8'(c));
			wr(la[5], 8'h00);
			ecc(3'b001);
			wr(la[5], 8'h00);
			ecc(3'b101);
			ecc(3'b010);
			rd(la[5]);
		end
		// counter saturates, first address kept, stray writes ignored
		repeat (16) ecc(3'b010);
		wr(la[5], 8'h5a);
		wr(la[6], 8'hff);
		for (int i = 5; i < 10; i++)
			rd(la[i]);
		wr(la[5], 8'h00);
		rd(la[5]);
		// command check flag only with parity checking on
		cmd();
		rd(la[11]);
		wr(la[10], 8'hf6);
		rd(la[10]);
		cfg_out();
		cmd();
		rd(la[11]);
		wr(la[11], 8'h00);
		rd(la[11]);
		// boot field sets mode after reset, power-on restores it
		do_reset(1'b0);
		cfg_out();
		do_reset(1'b1);
		cfg_out();
		rd(la[10]);
		// volatile preamble enable, one cycle late
		repeat (16) begin
			@(posedge clk);
			pe <= 1'($urandom);
			@(posedge clk);
			#1 chk("drive", pe, drive);
		end
		close_out();
	end
endmodule // ocr2_top_tb

`default_nettype wire
